// ===== logic/vads_pkg.sv
// package: constants, types and carriers of the vertical axis sequencer
`default_nettype none
package vads_pkg;

   // clock and time base
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned MS_NS = 1_000_000;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;

   // ceiling of the hardware enable drop delay, in ms (167)
   localparam logic [15:0] HW_DELAY_MAX_MS = 16'h00A7;

   // disable action selects that run a controlled stop first
   localparam logic [1:0] DIS_ACT_CS_THEN_OFF = 2'h2;
   localparam logic [1:0] DIS_ACT_CS_THEN_DB = 2'h3;

   // input function code that requests a controlled stop (13)
   localparam logic [3:0] IN_FUNC_CSTOP = 4'hD;
   localparam int unsigned NUM_DIN = 4;

   // settings as they stand after reset of the surrounding config store
   localparam logic BRAKE_NOW_RST = 1'b0;
   localparam logic [7:0] HW_DELAY_RST = 8'h00;

   // one-hot sequencer states
   typedef enum logic [4:0] {
      ST_OFF = 5'b0_0001,
      ST_RUN = 5'b0_0010,
      ST_CSTOP = 5'b0_0100,
      ST_BDELAY = 5'b0_1000,
      ST_HWDLY = 5'b1_0000
   } vads_state_t;

   // cause of the most recent disable
   typedef enum logic [2:0] {
      CAUSE_NONE = 3'h0,
      CAUSE_HW = 3'h1,
      CAUSE_SW = 3'h2,
      CAUSE_STO = 3'h3,
      CAUSE_FAULT = 3'h4,
      CAUSE_DIN = 3'h5
   } vads_cause_t;

   // static configuration carrier
   typedef struct packed {
      logic [1:0] disable_action_select;
      logic brake_on_disable_now;
      logic [7:0] hw_enable_drop_delay;
      logic [7:0] brake_delay;
      logic [15:0] disable_timeout;
      logic [15:0] stop_speed_threshold;
   } vads_cfg_t;

   // disable sources carrier
   typedef struct packed {
      logic hw_enable;
      logic sw_enable;
      logic safe_torque_off;
      logic fault;
      logic fault_cstop;
   } vads_src_t;

endpackage
`default_nettype wire

// ===== logic/vads_sequencer.sv
// vertical axis disable sequencer: power stage and holding brake order
`timescale 1ns/100ps
`default_nettype none

module vads_sequencer
   import vads_pkg::*;
#(
   parameter int unsigned MS_CYC = MS_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire vads_cfg_t cfg_i,
   input wire vads_src_t src_i,
   input wire logic [NUM_DIN-1:0] din_i,
   input wire logic [4*NUM_DIN-1:0] input_function_select_i,
   input wire logic [15:0] speed_i,
   output logic power_stage_en_o,
   output logic brake_engage_o,
   output logic zero_vel_cmd_o,
   output logic seq_busy_o,
   output logic [2:0] last_cause_o
);

   // clamp the drop delay to its ceiling
   // a setting above the ceiling is cut, never wrapped or ignored
   function automatic logic [15:0] clamp_hw(input logic [7:0] d);
      logic [15:0] w;
      w = {8'h00, d};
      if (w > HW_DELAY_MAX_MS) begin
         w = HW_DELAY_MAX_MS;
      end
      return w;
   endfunction

   // true when any active input carries the stop function
   // inputs set to any other function never start a stop
   function automatic logic din_stop(
      input logic [NUM_DIN-1:0] din,
      input logic [4*NUM_DIN-1:0] sel
   );
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_DIN; i++) begin
         if (din[i] && (sel[4*i +: 4] == IN_FUNC_CSTOP)) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // last prescaler count inside one millisecond
   localparam logic [15:0] PRE_LAST = 16'(MS_CYC - 1);

   // sequencer state, latched cause and the shared millisecond timer
   vads_state_t state_reg;
   vads_state_t state_next;
   vads_cause_t cause_reg;
   vads_cause_t cause_next;
   logic [15:0] pre_reg;
   logic [15:0] tmr_reg;
   logic load;
   logic [15:0] load_val;
   logic ms_tick;
   logic tdone;
   logic hard_cut;
   logic hw_lost;
   logic hw_hold;
   logic [15:0] hw_tgt;
   logic cs_req;
   logic sw_cs;
   logic all_ok;
   logic slow;
   logic brake_next;

   // cause decoding
   assign hard_cut = src_i.safe_torque_off | src_i.fault;
   assign hw_lost = ~src_i.hw_enable;
   assign cs_req = src_i.fault_cstop |
      din_stop(din_i, input_function_select_i);
   assign sw_cs = (cfg_i.disable_action_select == DIS_ACT_CS_THEN_OFF) |
      (cfg_i.disable_action_select == DIS_ACT_CS_THEN_DB);
   assign all_ok = ~hard_cut & ~hw_lost & ~cs_req & src_i.sw_enable;

   // drop delay target, zero means feature off
   assign hw_tgt = clamp_hw(cfg_i.hw_enable_drop_delay);
   assign hw_hold = (hw_tgt != 16'h0000);

   // stop is finished once the load runs below threshold
   assign slow = (speed_i < cfg_i.stop_speed_threshold);

   // one tick per millisecond; the timer parks at zero once run out
   assign ms_tick = (pre_reg == PRE_LAST);
   assign tdone = (tmr_reg == 16'h0000);

   // next state; torque off and faults always preempt other paths
   // the cause is latched only on leaving run, so the first cause wins
   always_comb begin
      state_next = state_reg;
      cause_next = cause_reg;
      load = 1'b0;
      load_val = 16'h0000;
      unique case (state_reg)
         ST_OFF: begin
            // restart only once every source is healthy again
            if (all_ok) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            // torque off outranks a fault when both arrive together
            if (hard_cut) begin
               state_next = ST_OFF;
               cause_next = src_i.safe_torque_off ? CAUSE_STO
                  : CAUSE_FAULT;
            end else if (hw_lost) begin
               cause_next = CAUSE_HW;
               // brake now, power kept for the clamped delay
               if (hw_hold) begin
                  state_next = ST_HWDLY;
                  load = 1'b1;
                  load_val = hw_tgt;
               end else begin
                  state_next = ST_OFF;
               end
            end else if (cs_req) begin
               state_next = ST_CSTOP;
               // a stop asked by a fault records the fault as cause
               cause_next = src_i.fault_cstop ? CAUSE_FAULT : CAUSE_DIN;
               load = 1'b1;
               load_val = cfg_i.disable_timeout;
            end else if (!src_i.sw_enable) begin
               cause_next = CAUSE_SW;
               // select 0 or 1 skips the stop and goes to brake delay
               load = 1'b1;
               if (sw_cs) begin
                  state_next = ST_CSTOP;
                  load_val = cfg_i.disable_timeout;
               end else begin
                  state_next = ST_BDELAY;
                  load_val = {8'h00, cfg_i.brake_delay};
               end
            end
         end
         ST_CSTOP: begin
            // a hard cut or enable loss overrides the running stop
            if (hard_cut) begin
               state_next = ST_OFF;
            end else if (hw_lost) begin
               if (hw_hold) begin
                  state_next = ST_HWDLY;
                  load = 1'b1;
                  load_val = hw_tgt;
               end else begin
                  state_next = ST_OFF;
               end
            end else if (slow || tdone) begin
               state_next = ST_BDELAY;
               load = 1'b1;
               load_val = {8'h00, cfg_i.brake_delay};
            end
         end
         ST_BDELAY: begin
            // power held so the load cannot sag before the brake bites
            if (hard_cut) begin
               state_next = ST_OFF;
            end else if (hw_lost) begin
               if (hw_hold) begin
                  state_next = ST_HWDLY;
                  load = 1'b1;
                  load_val = hw_tgt;
               end else begin
                  state_next = ST_OFF;
               end
            end else if (tdone) begin
               state_next = ST_OFF;
            end
         end
         ST_HWDLY: begin
            // a returning enable is ignored; the hold runs out unless a hard cut ends it first
            if (hard_cut || tdone) begin
               state_next = ST_OFF;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // disable cause, held until the next disable
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cause_reg <= CAUSE_NONE;
      end else begin
         cause_reg <= cause_next;
      end
   end

   // millisecond prescaler, restarted on each load so a delay is never
   // short by a partial millisecond
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_reg <= 16'h0000;
      end else if (load || ms_tick) begin
         pre_reg <= 16'h0000;
      end else begin
         pre_reg <= pre_reg + 16'h0001;
      end
   end

   // remaining milliseconds of the running delay or stop timeout
   // one counter serves all three delays since only one runs at a time
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tmr_reg <= 16'h0000;
      end else if (load) begin
         tmr_reg <= load_val;
      end else if (ms_tick && !tdone) begin
         tmr_reg <= tmr_reg - 16'h0001;
      end
   end

   // brake: released only while running; during a controlled stop it
   // waits for the stop end unless the brake-now setting is on
   always_comb begin
      brake_next = 1'b1;
      unique case (state_next)
         ST_OFF: brake_next = 1'b1;
         ST_RUN: brake_next = 1'b0;
         ST_CSTOP: brake_next = cfg_i.brake_on_disable_now;
         ST_BDELAY: brake_next = 1'b1;
         ST_HWDLY: brake_next = 1'b1;
      endcase
   end

   // power stage enable, decoded from the next state so that it moves
   // at the same edge as the state and adds no cycle of latency
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_stage_en_o <= 1'b0;
      end else begin
         power_stage_en_o <= (state_next != ST_OFF);
      end
   end

   // brake command; engaged out of reset so a vertical load never drops
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         brake_engage_o <= 1'b1;
      end else begin
         brake_engage_o <= brake_next;
      end
   end

   // zero velocity demand while stopping or holding on drop delay
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         zero_vel_cmd_o <= 1'b0;
      end else begin
         zero_vel_cmd_o <= (state_next == ST_CSTOP) ||
            (state_next == ST_HWDLY);
      end
   end

   // busy for every sequence step between run and off
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seq_busy_o <= 1'b0;
      end else begin
         seq_busy_o <= (state_next == ST_CSTOP) ||
            (state_next == ST_BDELAY) ||
            (state_next == ST_HWDLY);
      end
   end

   // cause output, registered from the next cause so it matches the cause register in every cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_cause_o <= 3'h0;
      end else begin
         last_cause_o <= cause_next;
      end
   end

endmodule
`default_nettype wire

// ===== bench/vads_checker.sv
// checker: port timing of the vertical axis disable sequencer
`timescale 1ns/100ps
`default_nettype none
module vads_checker
   import vads_pkg::*;
#(
   parameter int unsigned MS_CYC = 4
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire vads_cfg_t cfg_i,
   input wire vads_src_t src_i,
   input wire logic [NUM_DIN-1:0] din_i,
   input wire logic [4*NUM_DIN-1:0] input_function_select_i,
   input wire logic [15:0] speed_i,
   input wire logic power_stage_en_o,
   input wire logic brake_engage_o,
   input wire logic zero_vel_cmd_o,
   input wire logic seq_busy_o,
   input wire logic [2:0] last_cause_o
);
   localparam int HOLD_MAX = 167 * MS_CYC + 2;
   logic cs_req;
   logic [23:0] hold_reg;
   logic sane;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   assign sane = !src_i.safe_torque_off && !src_i.fault;
   // any active input mapped to the stop function asks for a stop
   always_comb begin
      cs_req = 1'b0;
      for (int i = 0; i < NUM_DIN; i++) begin
         if (din_i[i] && input_function_select_i[4*i+:4] == IN_FUNC_CSTOP)
            cs_req = 1'b1;
      end
   end
   // power held after enable loss; reset by a returning enable
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_reg <= 24'h00_0000;
      end else if (src_i.hw_enable || !power_stage_en_o) begin
         hold_reg <= 24'h00_0000;
      end else begin
         hold_reg <= hold_reg + 24'h00_0001;
      end
   end
   a_off_brake: assert property (
      !power_stage_en_o |-> brake_engage_o)
      else $error("brake released with power stage off");
   a_sto_cut: assert property (
      src_i.safe_torque_off |=> !power_stage_en_o)
      else $error("power kept after torque off");
   a_fault_cause: assert property (
      power_stage_en_o && !seq_busy_o && src_i.fault &&
      !src_i.safe_torque_off |=> last_cause_o == CAUSE_FAULT)
      else $error("fault not recorded as cause");
   a_hw_zero: assert property (
      power_stage_en_o && !src_i.hw_enable &&
      cfg_i.hw_enable_drop_delay == 8'h00 |=> !power_stage_en_o)
      else $error("power kept with zero drop delay");
   a_hw_delay: assert property ($fell(src_i.hw_enable) && sane &&
      power_stage_en_o && cfg_i.hw_enable_drop_delay != 8'h00
      |=> power_stage_en_o && brake_engage_o && zero_vel_cmd_o)
      else $error("drop delay entry wrong");
   a_hw_bound: assert property (hold_reg <= HOLD_MAX)
      else $error("power held beyond drop delay ceiling");
   a_cs_entry: assert property (
      power_stage_en_o && !seq_busy_o && cs_req && sane &&
      src_i.hw_enable |=> seq_busy_o && zero_vel_cmd_o)
      else $error("stop input did not start a stop");
   a_cs_end: assert property (seq_busy_o && !brake_engage_o &&
      speed_i < cfg_i.stop_speed_threshold |=> brake_engage_o)
      else $error("stop did not end at low speed");
   a_brake_now: assert property (seq_busy_o &&
      cfg_i.brake_on_disable_now |-> brake_engage_o)
      else $error("brake not engaged at once");
   a_busy_power: assert property (seq_busy_o |-> power_stage_en_o)
      else $error("power dropped inside a sequence");
endmodule
bind vads_sequencer vads_checker #(.MS_CYC(MS_CYC)) vads_checker_inst (
   .ref_clk_i, .rst_n_i, .cfg_i, .src_i, .din_i, .input_function_select_i,
   .speed_i, .power_stage_en_o, .brake_engage_o, .zero_vel_cmd_o,
   .seq_busy_o, .last_cause_o);
`default_nettype wire

// ===== bench/vads_motor_model.sv
// motor and load stand-in: speed falls while zero velocity is commanded and the power stage is on
`timescale 1ns/100ps
`default_nettype none
module vads_motor_model (
   input wire logic clk_i,
   input wire logic load_i,
   input wire logic [15:0] start_i,
   input wire logic power_i,
   input wire logic zero_vel_i,
   output logic [15:0] speed_o
);
   // only a live power stage slows the load; it coasts otherwise
   always_ff @(posedge clk_i) begin
      if (load_i) begin
         speed_o <= start_i;
      end else if (power_i && zero_vel_i && speed_o > 16'h0020) begin
         speed_o <= speed_o - 16'h0020;
      end
   end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// testbench: disable sequences of the vertical axis sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
   import vads_pkg::*;
   localparam int MSC = 4;
   logic clk, rst_n, pwr, brk, zv, busy, load;
   vads_cfg_t cfg;
   vads_src_t src;
   logic [3:0] din;
   logic [15:0] fsel, speed;
   logic [2:0] cause;
   int bad_count = 0;
   int checks_done = 0;
   vads_sequencer #(.MS_CYC(MSC)) vads_sequencer_inst (.ref_clk_i(clk),
      .rst_n_i(rst_n), .cfg_i(cfg), .src_i(src), .din_i(din),
      .input_function_select_i(fsel), .speed_i(speed),
      .power_stage_en_o(pwr), .brake_engage_o(brk), .zero_vel_cmd_o(zv),
      .seq_busy_o(busy), .last_cause_o(cause));
   vads_motor_model vads_motor_model_inst (.clk_i(clk), .load_i(load),
      .start_i(16'h0400), .power_i(pwr), .zero_vel_i(zv), .speed_o(speed));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic tick();
      @(posedge clk);
      #10;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // bring the drive up with every source healthy and a spinning motor
   task automatic up();
      src = 5'h18;
      din = 4'h0;
      load = 1'b1;
      tick();
      load = 1'b0;
      repeat (2) tick();
      chk("enable", {pwr, brk}, 2'b10);
   endtask
   // bounded wait for the power stage to drop; counts the edges
   task automatic off(output int n);
      n = 0;
      while (pwr !== 1'b0) begin
         tick();
         n++;
         if (n > 2000) begin
            bad_count++;
            close_out();
         end
      end
   endtask
   task automatic t_cut();
      vads_cause_t exp_c[3] = '{CAUSE_STO, CAUSE_FAULT, CAUSE_HW};
      logic [4:0] ev[3] = '{5'h1c, 5'h1a, 5'h08};
      for (int k = 0; k < 3; k++) begin
         up();
         src = ev[k];
         tick();
         chk("cut_power", {pwr, brk}, 2'b01);
         chk("cut_cause", cause, exp_c[k]);
      end
   endtask
   task automatic t_hwd();
      int n, d;
      for (int k = 0; k < 2; k++) begin
         d = k ? int'(HW_DELAY_MAX_MS) : 3;
         cfg.hw_enable_drop_delay = k ? 8'hC8 : 8'h03;
         up();
         src.hw_enable = 1'b0;
         tick();
         chk("hwd_state", {pwr, brk, zv}, 3'h7);
         off(n);
         chk("hwd_hold", n >= d*MSC && n <= d*MSC+2, 1'b1);
      end
      cfg.hw_enable_drop_delay = HW_DELAY_RST;
   endtask
   task automatic t_cs();
      int n;
      for (int i = 0; i < NUM_DIN; i++) begin
         up();
         fsel = 16'hCCCC;
         din = 4'hF;
         tick();
         chk("decoy_input", busy, 1'b0);
         fsel[4*i+:4] = IN_FUNC_CSTOP;
         din = 4'(1 << i);
         tick();
         chk("cs_enter", {pwr, brk, zv, busy}, 4'hB);
         off(n);
         chk("cs_end", n < 100 && speed < 16'h0100, 1'b1);
         chk("cs_cause", cause, CAUSE_DIN);
      end
      // a fault that asks for a stop takes the same stop path
      up();
      src.fault_cstop = 1'b1;
      tick();
      chk("fcs_enter", {pwr, brk, zv, busy}, 4'hB);
      off(n);
      chk("fcs_cause", cause, CAUSE_FAULT);
   endtask
   task automatic t_sw();
      int n;
      for (int s = 0; s < 4; s++) begin
         cfg.disable_action_select = 2'(s);
         up();
         src.sw_enable = 1'b0;
         tick();
         chk("sw_path", {busy, brk}, {1'b1, s < 2});
         off(n);
         chk("sw_delay", n >= MSC, 1'b1);
         chk("sw_cause", cause, CAUSE_SW);
      end
   endtask
   task automatic t_now();
      int n;
      cfg.brake_on_disable_now = 1'b1;
      cfg.disable_action_select = DIS_ACT_CS_THEN_DB;
      cfg.stop_speed_threshold = 16'h0000;
      cfg.disable_timeout = 16'h0002;
      up();
      src.sw_enable = 1'b0;
      tick();
      chk("now_brake", {brk, zv, busy}, 3'h7);
      off(n);
      chk("stop_timeout", n >= 3*MSC && n <= 3*MSC+4, 1'b1);
   endtask
   // main sequence; the stop threshold sits below the motor's start speed
   initial begin
      rst_n = 1'b0;
      cfg = '{2'h0, BRAKE_NOW_RST, HW_DELAY_RST, 8'h01, 16'h0064, 16'h0100};
      src = 5'h00;
      din = 4'h0;
      fsel = 16'h0000;
      load = 1'b0;
      repeat (10) @(posedge clk);
      #10;
      rst_n = 1'b1;
      chk("reset_out", {pwr, brk, busy}, 3'h2);
      t_cut();
      t_hwd();
      t_cs();
      t_sw();
      t_now();
      close_out();
   end
endmodule
`default_nettype wire
